/* core/csf_params.svh */
/*
 * register offsets, field positions, reset values, fault codes and timing figures of the
 * charger safety and fault logic. assumes a 250 mhz system clock; definitions only.
 */
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define CSF_R0_ADDR        8'h00
`define CSF_R1_ADDR        8'h01
`define CSF_R2_ADDR        8'h02
`define CSF_R4_ADDR        8'h04
`define CSF_R5_ADDR        8'h05
`define CSF_R6_ADDR        8'h06

// ************************************************************
// field positions
// ************************************************************
`define CSF_R1_ILIM_MSB    7
`define CSF_R1_ILIM_LSB    6
`define CSF_R1_TERM_EN_BIT 3
`define CSF_R2_VREG_MSB    7
`define CSF_R2_VREG_LSB    2
`define CSF_R4_ICHG_MSB    6
`define CSF_R4_ICHG_LSB    4
`define CSF_R5_HOLD_BIT    4
`define CSF_R6_ICEIL_MSB   6
`define CSF_R6_ICEIL_LSB   4
`define CSF_R6_VCEIL_MSB   3
`define CSF_R6_VCEIL_LSB   0

// ************************************************************
// reset values and encodings
// ************************************************************
`define CSF_R1_RST         8'h30
`define CSF_R2_RST         8'h0a
`define CSF_R4_RST         8'h09
`define CSF_R5_RST         3'h4
`define CSF_R6_RST         7'h40
`define CSF_VMAX_BASE      6'h23
`define CSF_FOLDBACK_CODE  3'h0

`define CSF_F_NONE         3'h0
`define CSF_F_OVP          3'h1
`define CSF_F_SLEEP        3'h2
`define CSF_F_POOR_SRC     3'h3
`define CSF_F_BAT_OVP      3'h4
`define CSF_F_THERMAL      3'h5
`define CSF_F_NO_BAT       3'h7

`define CSF_STAT_READY     2'h0
`define CSF_STAT_CHARGING  2'h1
`define CSF_STAT_DONE      2'h2
`define CSF_STAT_FAULT     2'h3

// ************************************************************
// timing
// ************************************************************
`define CSF_CLK_MHZ        250
`define CSF_T_RETRY_MS     2000
`define CSF_T_PWM_IDLE_MS  30
`define CSF_T_DETECT_MS    10
`define CSF_T_RAMP_US      64
`define CSF_T_STAT_US      128

`endif

/* core/csf_pkg.sv */
/*
 * types shared by the charger safety and fault logic.
 * assumes nothing of its surroundings.
 */
package csf_pkg;

	typedef enum logic [3:0] {
		CSF_VALIDATE,
		CSF_CHARGE,
		CSF_SLEEP,
		CSF_HOT,
		CSF_OVP,
		CSF_UV_WAIT,
		CSF_BAT_OVP,
		CSF_DETECT,
		CSF_RETRY,
		CSF_DONE
	} csf_state_t;

	typedef logic [2:0] csf_fault_t;
	typedef logic [1:0] csf_stat_t;

endpackage : csf_pkg

/* core/csf_stat_pulse.sv */
/*
 * single pulse generator for the status output.
 * assumes trig is synchronous to sys_clk and the pulse length is at least eight cycles.
 */
`timescale 1ns/1ps

module csf_stat_pulse #(
	parameter int unsigned PULSE_CYC = 32000
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic trig,
	output logic      pulse_q
);

	logic [31:0] cnt_q;
	wire         last_w = (cnt_q >= PULSE_CYC - 32'h1);

	// ************************************************************
	// pulse timer
	// ************************************************************
	// a trigger inside a running pulse is absorbed so faults never glitch the pin
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pulse_q <= 1'b0;
			cnt_q   <= 32'h0;
		end else if (ce) begin
			if (!pulse_q && trig) begin
				pulse_q <= 1'b1;
				cnt_q   <= 32'h0;
			end else if (pulse_q) begin
				pulse_q <= !last_w;
				cnt_q   <= cnt_q + 32'h1;
			end
		end
	end

	property p_pulse_starts;
		@(posedge sys_clk) disable iff (rst)
		(ce && trig && !pulse_q) |=> pulse_q;
	endproperty
	a_pulse_starts: assert property (p_pulse_starts) else $error("status pulse did not start");

	property p_pulse_holds;
		@(posedge sys_clk) disable iff (rst)
		$rose(pulse_q) |-> pulse_q [*8];
	endproperty
	a_pulse_holds: assert property (p_pulse_holds) else $error("status pulse too short");

endmodule : csf_stat_pulse

/* core/csf_charger_safety_fault.sv */
/*
 * charger safety register, code clamping, hold-loop status and charge fault handling.
 * assumes analog comparator results arrive as flags synchronous to sys_clk and that a
 * serial front end turns host traffic into the write and read strobes below.
 */
`timescale 1ns/1ps
`include "csf_params.svh"

// Operation
// - hold-loop status bit in register 5 bit 4 shows the hold loop limits current.
// - register 5 bits 2:0 pick the supply hold threshold, eight equal steps.
// - charge current ramps up, stops at limits, or holds while the hold loop acts.
// - safety register loads default below short threshold; writable before other writes.
// - any other register write locks safety register until battery drops below short.
// - regulation voltage code above the ceiling is stored as the ceiling.
// - charge current code above the current ceiling is stored as the ceiling.
// - voltage ceiling code n allows regulation code 100011 plus n.
// - current ceiling uses charge current encoding, compared code to code.
// - foldback cuts current to 550 mA; shutdown suspends, fault 101, status pulse.
// - thermal suspend clears timers, keeps ramp level and state, resumes at programmed current.
// - supply under battery plus margin but above minimum enters sleep, blocks reverse.
// - supply under minimum while charging ends charge, pulse, status 11, fault 011.
// - after undervoltage, recovered supply past retry interval restarts charging.
// - overvoltage opens input switch, suspends, fault 001, status 11, pulse.
// - overvoltage clears on falling flag, charging waits for supply revalidation.
// - no pwm pulse for 30 ms without termination gives fault 100, status 11, pulse.
// - with termination on, termination ends charge, status 10, detect sink applied.
// - battery still above recharge level after detect means present, fault 000.
// - battery below recharge level resets registers 1, 2, 4 and 5, fault 111, retries with defaults.
// - battery below short threshold is fed by linear source until above it.
// - fault code sits in register 0 bits 2:0.
// - status bits read 00 ready, 10 done after termination.
module csf_charger_safety_fault #(
	parameter int unsigned RETRY_CYC      = `CSF_T_RETRY_MS * `CSF_CLK_MHZ * 1000,
	parameter int unsigned PWM_IDLE_CYC   = `CSF_T_PWM_IDLE_MS * `CSF_CLK_MHZ * 1000,
	parameter int unsigned DETECT_CYC     = `CSF_T_DETECT_MS * `CSF_CLK_MHZ * 1000,
	parameter int unsigned RAMP_STEP_CYC  = `CSF_T_RAMP_US * `CSF_CLK_MHZ,
	parameter int unsigned STAT_PULSE_CYC = `CSF_T_STAT_US * `CSF_CLK_MHZ
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata_q,
	input  wire logic       vbus_validated,
	input  wire logic       vbus_ovp_flag,
	input  wire logic       vbus_uv_flag,
	input  wire logic       vbus_sleep_flag,
	input  wire logic       thermal_foldback_flag,
	input  wire logic       thermal_shutdown_flag,
	input  wire logic       vbat_above_short_flag,
	input  wire logic       vbat_near_reg_flag,
	input  wire logic       vbat_above_rch_flag,
	input  wire logic       term_current_flag,
	input  wire logic       hold_loop_active_flag,
	input  wire logic       pwm_pulse,
	output logic            pwm_charge_en,
	output logic            linear_source_en,
	output logic            input_switch_on,
	output logic            reverse_block_en,
	output logic            detect_sink_en,
	output logic      [2:0] charge_current_cmd_q,
	output logic      [5:0] regulation_voltage_cmd,
	output logic      [1:0] input_current_limit_code,
	output logic      [2:0] supply_hold_threshold,
	output logic            stat_pulse_q
);

	// ************************************************************
	// decode helpers
	// ************************************************************
	function automatic logic [5:0] csf_vmax(input logic [3:0] vceil);
		csf_vmax = `CSF_VMAX_BASE + {2'h0, vceil};
	endfunction : csf_vmax

	function automatic logic [5:0] csf_min6(input logic [5:0] a, input logic [5:0] b);
		csf_min6 = (a > b) ? b : a;
	endfunction : csf_min6

	csf_pkg::csf_state_t state_q;
	csf_pkg::csf_state_t state_d;
	csf_pkg::csf_fault_t fault_q;
	csf_pkg::csf_fault_t fault_d;
	csf_pkg::csf_stat_t  stat_q;
	csf_pkg::csf_stat_t  stat_d;
	logic [7:0]          r1_q;
	logic [5:0]          vreg_code_q;
	logic [1:0]          r2_low_q;
	logic [2:0]          ichg_q;
	logic [2:0]          r5_q;
	logic                hold_q;
	logic [6:0]          safe_q;
	logic                lock_q;
	logic [31:0]         tmr_q;
	logic [31:0]         ramp_cnt_q;
	logic [2:0]          ramp_q;
	logic                tmr_run;
	logic                fault_evt;
	logic                load_defaults;

	wire       wr_r1    = reg_wr && (reg_addr == `CSF_R1_ADDR);
	wire       wr_r2    = reg_wr && (reg_addr == `CSF_R2_ADDR);
	wire       wr_r4    = reg_wr && (reg_addr == `CSF_R4_ADDR);
	wire       wr_r5    = reg_wr && (reg_addr == `CSF_R5_ADDR);
	wire       wr_r6    = reg_wr && (reg_addr == `CSF_R6_ADDR);
	wire       wr_other = reg_wr && (reg_addr != `CSF_R6_ADDR);
	wire [3:0] vceil_w  = safe_q[`CSF_R6_VCEIL_MSB:`CSF_R6_VCEIL_LSB];
	wire [2:0] iceil_w  = safe_q[`CSF_R6_ICEIL_MSB:`CSF_R6_ICEIL_LSB];
	wire [5:0] vmax_w   = csf_vmax(vceil_w);
	wire [5:0] vreg_in  = reg_wdata[`CSF_R2_VREG_MSB:`CSF_R2_VREG_LSB];
	wire [2:0] ichg_in  = reg_wdata[`CSF_R4_ICHG_MSB:`CSF_R4_ICHG_LSB];
	wire       term_en_w    = r1_q[`CSF_R1_TERM_EN_BIT];
	wire       charging = (state_q == csf_pkg::CSF_CHARGE);
	wire       tmr_retry_w  = (tmr_q >= RETRY_CYC - 32'h1);
	wire       tmr_idle_w   = (tmr_q >= PWM_IDLE_CYC - 32'h1);
	wire       tmr_detect_w = (tmr_q >= DETECT_CYC - 32'h1);
	wire       ramp_tick_w  = (ramp_cnt_q >= RAMP_STEP_CYC - 32'h1);
	wire [2:0] ichg_lim_w   = (ichg_q > iceil_w) ? iceil_w : ichg_q;
	wire [2:0] ichg_tgt_w   = thermal_foldback_flag ? `CSF_FOLDBACK_CODE : ichg_lim_w;
	wire [2:0] ramp_next_w  = ramp_q + 3'h1;

	// ************************************************************
	// charge sequencer
	// ************************************************************
	// all flags but foldback, hold-loop and battery-short are sampled here on sys_clk; comparators are trusted to be synchronous
	always_comb begin
		state_d       = state_q;
		fault_d       = fault_q;
		stat_d        = stat_q;
		tmr_run       = 1'b0;
		fault_evt     = 1'b0;
		load_defaults = 1'b0;
		unique case (state_q)
			csf_pkg::CSF_VALIDATE: begin
				if (vbus_validated) begin
					state_d = csf_pkg::CSF_CHARGE;
					stat_d  = `CSF_STAT_CHARGING;
				end
			end
			csf_pkg::CSF_CHARGE: begin
				tmr_run = !term_en_w;
				if (vbus_ovp_flag) begin
					state_d   = csf_pkg::CSF_OVP;
					fault_d   = `CSF_F_OVP;
					stat_d    = `CSF_STAT_FAULT;
					fault_evt = 1'b1;
				end else if (thermal_shutdown_flag) begin
					state_d   = csf_pkg::CSF_HOT;
					fault_d   = `CSF_F_THERMAL;
					fault_evt = 1'b1;
				end else if (vbus_uv_flag) begin
					state_d   = csf_pkg::CSF_UV_WAIT;
					fault_d   = `CSF_F_POOR_SRC;
					stat_d    = `CSF_STAT_FAULT;
					fault_evt = 1'b1;
				end else if (vbus_sleep_flag) begin
					state_d = csf_pkg::CSF_SLEEP;
					fault_d = `CSF_F_SLEEP;
				end else if (!term_en_w && tmr_idle_w) begin
					state_d   = csf_pkg::CSF_BAT_OVP;
					fault_d   = `CSF_F_BAT_OVP;
					stat_d    = `CSF_STAT_FAULT;
					fault_evt = 1'b1;
				end else if (term_en_w && vbat_near_reg_flag && term_current_flag) begin
					state_d = csf_pkg::CSF_DETECT;
					stat_d  = `CSF_STAT_DONE;
				end
			end
			csf_pkg::CSF_SLEEP: begin
				if (vbus_uv_flag) begin
					state_d = csf_pkg::CSF_UV_WAIT;
				end else if (!vbus_sleep_flag) begin
					state_d = csf_pkg::CSF_CHARGE;
					fault_d = `CSF_F_NONE;
				end
			end
			// nothing runs here, so tmr_q and ramp_q keep their values; ramp_cnt_q is held at zero
			csf_pkg::CSF_HOT: begin
				if (!thermal_shutdown_flag) begin
					state_d = csf_pkg::CSF_CHARGE;
				end
			end
			csf_pkg::CSF_OVP: begin
				if (!vbus_ovp_flag) begin
					state_d = csf_pkg::CSF_VALIDATE;
					fault_d = `CSF_F_NONE;
					stat_d  = `CSF_STAT_READY;
				end
			end
			csf_pkg::CSF_UV_WAIT: begin
				tmr_run = !tmr_retry_w;
				if (tmr_retry_w && !vbus_uv_flag) begin
					state_d = csf_pkg::CSF_VALIDATE;
					stat_d  = `CSF_STAT_READY;
				end
			end
			csf_pkg::CSF_BAT_OVP: begin
				if (pwm_pulse) begin
					state_d = csf_pkg::CSF_CHARGE;
					fault_d = `CSF_F_NONE;
					stat_d  = `CSF_STAT_CHARGING;
				end
			end
			csf_pkg::CSF_DETECT: begin
				tmr_run = 1'b1;
				if (tmr_detect_w && vbat_above_rch_flag) begin
					state_d = csf_pkg::CSF_DONE;
					fault_d = `CSF_F_NONE;
				end else if (tmr_detect_w) begin
					state_d       = csf_pkg::CSF_RETRY;
					fault_d       = `CSF_F_NO_BAT;
					load_defaults = 1'b1;
				end
			end
			csf_pkg::CSF_RETRY: begin
				tmr_run = 1'b1;
				if (tmr_retry_w) begin
					state_d = csf_pkg::CSF_VALIDATE;
					stat_d  = `CSF_STAT_READY;
				end
			end
			csf_pkg::CSF_DONE: begin
				if (!vbat_above_rch_flag) begin
					state_d = csf_pkg::CSF_VALIDATE;
					stat_d  = `CSF_STAT_READY;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= csf_pkg::CSF_VALIDATE;
			fault_q <= `CSF_F_NONE;
			stat_q  <= `CSF_STAT_READY;
			tmr_q   <= 32'h0;
		end else if (ce) begin
			state_q <= state_d;
			fault_q <= fault_d;
			stat_q  <= stat_d;
			if ((state_d != state_q) || (charging && pwm_pulse)) begin
				tmr_q <= 32'h0;
			end else if (tmr_run) begin
				tmr_q <= tmr_q + 32'h1;
			end
		end
	end

	// ************************************************************
	// host registers
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r1_q        <= `CSF_R1_RST;
			vreg_code_q <= 6'(`CSF_R2_RST >> 2);
			r2_low_q    <= 2'h2;
			ichg_q      <= 3'h0;
			r5_q        <= `CSF_R5_RST;
		end else if (ce) begin
			if (load_defaults) begin
				r1_q        <= `CSF_R1_RST;
				vreg_code_q <= 6'(`CSF_R2_RST >> 2);
				r2_low_q    <= 2'h2;
				ichg_q      <= 3'h0;
				r5_q        <= `CSF_R5_RST;
			end else begin
				if (wr_r1) begin
					r1_q <= reg_wdata;
				end
				if (wr_r2) begin
					vreg_code_q <= csf_min6(vreg_in, vmax_w);
					r2_low_q    <= reg_wdata[1:0];
				end
				if (wr_r4) begin
					ichg_q <= (ichg_in > iceil_w) ? iceil_w : ichg_in;
				end
				if (wr_r5) begin
					r5_q <= reg_wdata[2:0];
				end
			end
		end
	end

	// the lock is released only by reset or by the battery falling below the short level
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			safe_q <= `CSF_R6_RST;
			lock_q <= 1'b0;
		end else if (ce) begin
			if (!vbat_above_short_flag) begin
				safe_q <= `CSF_R6_RST;
				lock_q <= 1'b0;
			end else begin
				if (wr_r6 && !lock_q) begin
					safe_q <= reg_wdata[6:0];
				end
				if (wr_other) begin
					lock_q <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata_q <= 8'h00;
			hold_q      <= 1'b0;
		end else if (ce) begin
			hold_q <= hold_loop_active_flag && charging;
			if (reg_rd) begin
				unique case (reg_addr)
					`CSF_R0_ADDR: reg_rdata_q <= {2'h0, stat_q, 1'b0, fault_q};
					`CSF_R1_ADDR: reg_rdata_q <= r1_q;
					`CSF_R2_ADDR: reg_rdata_q <= {vreg_code_q, r2_low_q};
					`CSF_R4_ADDR: reg_rdata_q <= {1'b0, ichg_q, 4'h0};
					`CSF_R5_ADDR: reg_rdata_q <= {3'h0, hold_q, 1'b0, r5_q};
					`CSF_R6_ADDR: reg_rdata_q <= {1'b0, safe_q};
					default:      reg_rdata_q <= 8'h00;
				endcase
			end
		end
	end

	// ************************************************************
	// soft current ramp
	// ************************************************************
	// the ramp restarts from the lowest code on every new charge entry except a return from CSF_HOT
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ramp_q               <= 3'h0;
			ramp_cnt_q           <= 32'h0;
			charge_current_cmd_q <= 3'h0;
		end else if (ce) begin
			charge_current_cmd_q <= (ramp_q > ichg_tgt_w) ? ichg_tgt_w : ramp_q;
			if (!charging) begin
				if (state_q != csf_pkg::CSF_HOT) begin
					ramp_q <= 3'h0;
				end
				ramp_cnt_q <= 32'h0;
			end else if (hold_loop_active_flag || ramp_q >= ichg_tgt_w) begin
				ramp_cnt_q <= 32'h0;
			end else if (ramp_tick_w) begin
				ramp_q     <= ramp_next_w;
				ramp_cnt_q <= 32'h0;
			end else begin
				ramp_cnt_q <= ramp_cnt_q + 32'h1;
			end
		end
	end

	// ************************************************************
	// power path controls
	// ************************************************************
	assign pwm_charge_en            = charging && vbat_above_short_flag;
	assign linear_source_en         = charging && !vbat_above_short_flag;
	assign input_switch_on          = (state_q != csf_pkg::CSF_OVP);
	assign reverse_block_en         = (state_q == csf_pkg::CSF_SLEEP);
	assign detect_sink_en           = (state_q == csf_pkg::CSF_DETECT);
	assign regulation_voltage_cmd   = csf_min6(vreg_code_q, vmax_w);
	assign input_current_limit_code = r1_q[`CSF_R1_ILIM_MSB:`CSF_R1_ILIM_LSB];
	assign supply_hold_threshold    = r5_q;

	csf_stat_pulse #(
		.PULSE_CYC (STAT_PULSE_CYC)
	) u_stat_pulse (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.trig    (fault_evt),
		.pulse_q (stat_pulse_q)
	);

	// ************************************************************
	// checks
	// ************************************************************
	property p_vclamp;
		@(posedge sys_clk) disable iff (rst)
		(ce && wr_r2 && !load_defaults && vreg_in > vmax_w) |=> (vreg_code_q == $past(vmax_w));
	endproperty
	a_vclamp: assert property (p_vclamp) else $error("voltage code not clamped");

	property p_iclamp;
		@(posedge sys_clk) disable iff (rst)
		(ce && wr_r4 && !load_defaults && ichg_in > iceil_w) |=> (ichg_q == $past(iceil_w));
	endproperty
	a_iclamp: assert property (p_iclamp) else $error("current code not clamped");

	property p_lock;
		@(posedge sys_clk) disable iff (rst)
		(ce && lock_q && vbat_above_short_flag) |=> (safe_q == $past(safe_q));
	endproperty
	a_lock: assert property (p_lock) else $error("locked safety value changed");

	property p_safe_default;
		@(posedge sys_clk) disable iff (rst)
		(ce && !vbat_above_short_flag) |=> (safe_q == `CSF_R6_RST) && !lock_q;
	endproperty
	a_safe_default: assert property (p_safe_default) else $error("safety default not loaded");

	property p_ovp;
		@(posedge sys_clk) disable iff (rst)
		(ce && charging && vbus_ovp_flag) |=> (fault_q == `CSF_F_OVP) && (stat_q == `CSF_STAT_FAULT)
			&& !input_switch_on ##1 stat_pulse_q;
	endproperty
	a_ovp: assert property (p_ovp) else $error("overvoltage reaction wrong");

	property p_uv;
		@(posedge sys_clk) disable iff (rst)
		(ce && charging && !vbus_ovp_flag && !thermal_shutdown_flag && vbus_uv_flag)
			|=> (fault_q == `CSF_F_POOR_SRC) && !pwm_charge_en && !linear_source_en;
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage reaction wrong");

	property p_foldback;
		@(posedge sys_clk) disable iff (rst)
		(ce && thermal_foldback_flag) |=> (charge_current_cmd_q == `CSF_FOLDBACK_CODE);
	endproperty
	a_foldback: assert property (p_foldback) else $error("foldback current not applied");

	property p_hot_freeze;
		@(posedge sys_clk) disable iff (rst)
		(ce && state_q == csf_pkg::CSF_HOT && $past(state_q) == csf_pkg::CSF_HOT) |-> $stable(tmr_q);
	endproperty
	a_hot_freeze: assert property (p_hot_freeze) else $error("timer ran in thermal suspend");

endmodule : csf_charger_safety_fault

/* verif/csf_host_model.sv */
/*
 * host side of the register port: write and read tasks on the strobe protocol.
 * assumes the device takes a strobe on the rising edge of sys_clk.
 */
`timescale 1ns/1ps

module csf_host_model (
	input  wire logic       sys_clk,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata_q
);
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
	end

	// released lines show the inverse, so a stale value never passes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(negedge sys_clk);
		{reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		{reg_addr, reg_rd} = {a, 1'b1};
		@(negedge sys_clk);
		{reg_addr, reg_rd} = {~a, 1'b0};
		d = reg_rdata_q;
	endtask : rd

	task automatic wr_safety(input logic [7:0] d);
		wr(8'h06, d);
		wr(8'h06, d);
	endtask : wr_safety
endmodule : csf_host_model

/* verif/tb_top.sv */
/*
 * self-checking bench of the charger safety and fault logic.
 * assumes short timing parameters and a host model on the register port.
 */
`timescale 1ns/1ps

module tb_top;
	logic       sys_clk, rst, ce, reg_wr, reg_rd, pwm_pulse, pwm_run, pwm_charge_en, linear_source_en;
	logic       vbus_validated, vbus_ovp_flag, vbus_uv_flag, vbus_sleep_flag, input_switch_on;
	logic       thermal_foldback_flag, thermal_shutdown_flag, vbat_above_short_flag, reverse_block_en;
	logic       vbat_near_reg_flag, vbat_above_rch_flag, term_current_flag, hold_loop_active_flag;
	logic       detect_sink_en, stat_pulse_q;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
	logic [2:0] charge_current_cmd_q, supply_hold_threshold;
	logic [5:0] regulation_voltage_cmd;
	logic [1:0] input_current_limit_code;
	int         n_mismatch = 0;
	int         n_tests = 0;

	csf_charger_safety_fault #(.RETRY_CYC(50), .PWM_IDLE_CYC(40), .DETECT_CYC(20), .RAMP_STEP_CYC(4),
		.STAT_PULSE_CYC(10)) uut (.sys_clk, .rst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata_q, .vbus_validated, .vbus_ovp_flag, .vbus_uv_flag, .vbus_sleep_flag,
		.thermal_foldback_flag, .thermal_shutdown_flag, .vbat_above_short_flag, .vbat_near_reg_flag,
		.vbat_above_rch_flag, .term_current_flag, .hold_loop_active_flag, .pwm_pulse, .pwm_charge_en,
		.linear_source_en, .input_switch_on, .reverse_block_en, .detect_sink_en, .charge_current_cmd_q,
		.regulation_voltage_cmd, .input_current_limit_code, .supply_hold_threshold, .stat_pulse_q);
	csf_host_model host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q);

	always #2 sys_clk = ~sys_clk;
	// pwm activity keeps the idle-pulse watchdog quiet unless a test stops it
	always @(negedge sys_clk) pwm_pulse <= pwm_run & ~pwm_pulse;

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		logic [7:0] d;
		host.rd(a, d);
		chk(d & m, e);
	endtask : rdc

	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : wt

	task automatic wait_chg;
		for (int i = 0; i < 200 && pwm_charge_en !== 1'b1; i++) @(negedge sys_clk);
		chk({7'h0, pwm_charge_en}, 8'h01);
		if (pwm_charge_en !== 1'b1) report_and_stop;
	endtask : wait_chg

	task automatic flt(input logic [7:0] e, input logic [7:0] m);
		wt(3);
		chk({7'h0, stat_pulse_q}, 8'h01);
		rdc(8'h00, e, m);
		wt(12);
	endtask : flt

	initial begin
		{sys_clk, ce, pwm_run, pwm_pulse, vbus_validated, vbus_ovp_flag, vbus_uv_flag} = 7'h20;
		{vbus_sleep_flag, thermal_foldback_flag, thermal_shutdown_flag, hold_loop_active_flag} = '0;
		{vbat_above_short_flag, vbat_near_reg_flag, vbat_above_rch_flag, term_current_flag} = 4'h8;
		rst = 1'b1;
		wt(16);
		rst = 1'b0;
		rdc(8'h06, 8'h40);
		rdc(8'h00, 8'h00);
		host.wr_safety(8'h32);
		rdc(8'h06, 8'h32);
		host.wr(8'h02, 8'hfc);
		rdc(8'h02, 8'h94);
		chk({2'h0, regulation_voltage_cmd}, 8'h25);
		host.wr(8'h04, 8'h70);
		rdc(8'h04, 8'h30);
		host.wr(8'h06, 8'h7f);
		rdc(8'h06, 8'h32);
		vbat_above_short_flag = 1'b0;
		wt(2);
		vbat_above_short_flag = 1'b1;
		wt(2);
		rdc(8'h06, 8'h40);
		host.wr_safety(8'h7f);
		host.wr(8'h02, 8'hfc);
		rdc(8'h02, 8'hc8);
		host.wr(8'h04, 8'h70);
		rdc(8'h04, 8'h70);
		for (int k = 0; k < 8; k++) begin
			host.wr(8'h05, 8'(k));
			chk({5'h0, supply_hold_threshold}, 8'(k));
		end
		$display("done registers");
		{pwm_run, vbus_validated} = 2'b11;
		wait_chg;
		wt(40);
		chk({5'h0, charge_current_cmd_q}, 8'h07);
		hold_loop_active_flag = 1'b1;
		wt(3);
		rdc(8'h05, 8'h17);
		{hold_loop_active_flag, thermal_foldback_flag} = 2'b01;
		wt(2);
		chk({5'h0, charge_current_cmd_q}, 8'h00);
		{thermal_foldback_flag, thermal_shutdown_flag} = 2'b01;
		flt(8'h05, 8'h07);
		thermal_shutdown_flag = 1'b0;
		wait_chg;
		wt(2);
		chk({5'h0, charge_current_cmd_q}, 8'h07);
		$display("done ramp and thermal");
		vbus_ovp_flag = 1'b1;
		flt(8'h31, 8'hff);
		chk({7'h0, input_switch_on}, 8'h00);
		{vbus_ovp_flag, vbus_validated} = 2'b00;
		wt(5);
		chk({7'h0, pwm_charge_en}, 8'h00);
		vbus_validated = 1'b1;
		wait_chg;
		vbus_uv_flag = 1'b1;
		flt(8'h33, 8'hff);
		vbus_uv_flag = 1'b0;
		wt(20);
		chk({7'h0, pwm_charge_en}, 8'h00);
		wait_chg;
		vbus_sleep_flag = 1'b1;
		wt(3);
		chk({7'h0, reverse_block_en}, 8'h01);
		rdc(8'h00, 8'h02, 8'h07);
		vbus_sleep_flag = 1'b0;
		wait_chg;
		pwm_run = 1'b0;
		wt(43);
		flt(8'h34, 8'hff);
		pwm_run = 1'b1;
		wait_chg;
		// a frozen block must ignore even a fault flag
		{ce, vbus_ovp_flag} = 2'b01;
		wt(4);
		chk({7'h0, input_switch_on}, 8'h01);
		{ce, vbus_ovp_flag} = 2'b10;
		wt(2);
		chk({7'h0, pwm_charge_en}, 8'h01);
		$display("done supply faults");
		host.wr(8'h01, 8'hb8);
		chk({6'h0, input_current_limit_code}, 8'h02);
		{vbat_above_rch_flag, vbat_near_reg_flag, term_current_flag} = 3'b111;
		wt(3);
		chk({7'h0, detect_sink_en}, 8'h01);
		rdc(8'h00, 8'h20);
		{vbat_near_reg_flag, term_current_flag} = 2'b00;
		wt(25);
		rdc(8'h00, 8'h20);
		vbat_above_rch_flag = 1'b0;
		wait_chg;
		{vbat_near_reg_flag, term_current_flag} = 2'b11;
		wt(3);
		{vbat_near_reg_flag, term_current_flag} = 2'b00;
		wt(25);
		rdc(8'h00, 8'h07, 8'h07);
		rdc(8'h01, 8'h30);
		wait_chg;
		vbat_above_short_flag = 1'b0;
		wt(3);
		chk({6'h0, linear_source_en, pwm_charge_en}, 8'h02);
		host.wr(8'h05, 8'h01);
		rst = 1'b1;
		wt(2);
		rst = 1'b0;
		rdc(8'h05, 8'h04, 8'h07);
		rdc(8'h00, 8'h00, 8'h07);
		$display("done battery");
		report_and_stop;
	end
endmodule : tb_top
